// ==== hw/ssp_pkg.sv ====
/*
  Constants for the synchronous slave serial port: register offsets,
  field positions, reset values and encodings.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package ssp_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_RCV_STAT = 8'h00;  // receive_status_control
  localparam logic [7:0] OFF_TX_STAT  = 8'h04;  // transmit_status_control
  localparam logic [7:0] OFF_RX_DATA  = 8'h08;  // receive_data
  localparam logic [7:0] OFF_TX_DATA  = 8'h0c;  // transmit data register
  localparam logic [7:0] OFF_INT_CTRL = 8'h10;  // flags and interrupt enables

  // Receive status/control field positions
  localparam int RS_SERIAL_PORT_ENABLE  = 7;
  localparam int RS_RX9   = 6;
  localparam int RS_SINGLE_RECEIVE_ENABLE  = 5;
  localparam int RS_CONTINUOUS_RECEIVE_ENABLE  = 4;
  localparam int RS_ADDRESS_DETECT_ENABLE = 3;
  localparam int RS_FRAMING_ERROR_FLAG  = 2;
  localparam int RS_OVERRUN_ERROR_FLAG  = 1;
  localparam int RS_RECEIVED_NINTH_BIT  = 0;

  // Transmit status/control field positions
  localparam int TS_CLOCK_MASTER_SELECT = 7;
  localparam int TS_TX9  = 6;
  localparam int TS_TRANSMIT_ENABLE = 5;
  localparam int TS_SYNC = 4;
  localparam int TS_BAUD_HIGH_SPEED_SELECT = 2;
  localparam int TS_SHIFT_REGISTER_EMPTY = 1;
  localparam int TS_TRANSMIT_NINTH_BIT = 0;

  // Interrupt control field positions
  localparam int IC_RECEIVE_COMPLETE_FLAG = 0;
  localparam int IC_TRANSMIT_BUFFER_EMPTY_FLAG = 1;
  localparam int IC_RECEIVE_INTERRUPT_ENABLE = 4;
  localparam int IC_TRANSMIT_INTERRUPT_ENABLE = 5;
  localparam int IC_PERIPHERAL_INTERRUPT_ENABLE = 6;
  localparam int IC_GIE  = 7;

  // Reset values
  localparam logic [7:0] RCV_STAT_RST = 8'h00;
  localparam logic [7:0] TX_STAT_RST  = 8'h02;
  localparam logic [7:0] RX_DATA_RST  = 8'h00;
  localparam logic [7:0] INT_CTRL_RST = 8'h00;

  // Character lengths in bits
  localparam logic [3:0] CHAR_LEN_8 = 4'h8;
  localparam logic [3:0] CHAR_LEN_9 = 4'h9;

  // Interrupt vector address
  localparam logic [11:0] VECTOR_ADDR = 12'h004;

  // Transmit shifter states
  typedef enum logic [0:0] {
    TXS_IDLE  = 1'b0,
    TXS_SHIFT = 1'b1
  } ssp_tx_state_t;

endpackage

// ==== hw/ssp_link_if.sv ====
/*
  Carries the synchronised serial clock edges and data level from the
  pin synchroniser to the port core.
  Assumes both ends run on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
interface ssp_link_if;
  logic rise;   // Clock pin rose, one-cycle pulse
  logic fall;   // Clock pin fell, one-cycle pulse
  logic data;   // Synchronised data pin level

  modport src  (output rise, output fall, output data);
  modport sink (input rise, input fall, input data);
endinterface
`default_nettype wire

// ==== hw/ssp_pin_sync.sv ====
/*
  Two-flop synchronisers for the serial clock and data pins, with edge
  detection on the synchronised clock.
  Assumes pins are asynchronous to pclk and slow beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_pin_sync
  import ssp_pkg::*;
(
  input  wire logic   pclk,      // Processor clock
  input  wire logic   presetn,   // Asynchronous reset, active low
  input  wire logic   clk_pin,   // Serial clock from master
  input  wire logic   data_pin,  // Serial data pin input
  ssp_link_if.src     link       // Synchronised edges and data
);
  logic [2:0] ck_r;
  logic [2:0] ck_nxt;
  logic [1:0] dt_r;
  logic [1:0] dt_nxt;

  // Shift chains; stage 0 feeds only stage 1
  always_comb begin
    ck_nxt = {ck_r[1:0], clk_pin};
    dt_nxt = {dt_r[0], data_pin};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ck_r <= 3'h0;
      dt_r <= 2'h0;
    end else begin
      ck_r <= ck_nxt;
      dt_r <= dt_nxt;
    end
  end

  // Edges from stages 1 and 2 only
  assign link.rise = ck_r[1] & ~ck_r[2];
  assign link.fall = ~ck_r[1] & ck_r[2];
  assign link.data = dt_r[1];
endmodule
`default_nettype wire

// ==== hw/ssp_top.sv ====
/*
  Synchronous slave serial port core: APB registers, slave receiver
  with receive queue, slave transmitter with buffer, wake and
  interrupt requests.
  Assumes an external master drives the serial clock; pins reach the
  core through ssp_pin_sync.
*/
// The implementer's own choices: the register addresses and register access over APB.
// Operation
// - Slave mode needs sync and port enable set, clock master select clear.
// - Nine-bit receive option captures a ninth bit per character.
// - Continuous receive enable lets the slave shift in externally clocked characters.
// - Completed character sets receive flag; enabled flag raises interrupt request.
// - Ninth bit read in receive status; low byte read from receive data queue.
// - Clearing continuous receive enable clears the overrun flag.
// - Reading receive data unloads queue; flag clears once queue is empty.
// - In sleep only slave mode shifts; other modes stop.
// - Shift registers advance only on the external clock pin edges.
// - Asleep, a received word sets the flag and wakes when enabled.
// - After wake: resume next instruction, or vector to 004h with global enable.
// - Writing transmit data fills shift register and buffer, clearing buffer-empty flag.
// - Asleep in transmit, accept clocks and drive data onto data pin.
// - Word shifted out: buffered byte moves in, buffer-empty flag set, wake.
// - Writing another character clears the buffer-empty flag again.
// - Single-receive bit ignored in slave mode; continuous receive governs receiver.
// - Both receive bits clear selects transmit direction, otherwise receive.
`timescale 1ns/1ps
`default_nettype none
module ssp_top
  import ssp_pkg::*;
#(
  parameter int RXQ_DEPTH = 2
) (
  input  wire logic        pclk,                  // Processor clock, 40 MHz
  input  wire logic        presetn,               // Asynchronous reset, active low
  input  wire logic        psel,                  // APB select
  input  wire logic        penable,               // APB enable
  input  wire logic        pwrite,                // APB write
  input  wire logic [7:0]  paddr,                 // APB byte address
  input  wire logic [31:0] pwdata,                // APB write data
  output logic      [31:0] prdata,                // APB read data
  output logic             pready,                // APB ready
  output logic             pslverr,               // APB error, unmapped address
  input  wire logic        serial_clock_pin,      // Clock from external master
  input  wire logic        serial_data_pin_in,    // Data pin level
  output logic             serial_data_pin_out,   // Data pin drive value
  output logic             serial_data_pin_oe_n,  // Data pin drive, active low
  input  wire logic        cpu_sleep,             // Processor asleep
  output logic             irq_o,                 // Interrupt request
  output logic             wake_o,                // Wake from sleep
  output logic             resume_next_o,         // Wake with no vector
  output logic      [11:0] vector_addr_o          // Vector address while irq_o
);
  localparam int QW = (RXQ_DEPTH > 1) ? $clog2(RXQ_DEPTH) : 1;
  localparam logic [QW:0] QFULL = (QW+1)'(RXQ_DEPTH);

  ssp_link_if link ();

  ssp_pin_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_pin  (serial_clock_pin),
    .data_pin (serial_data_pin_in),
    .link     (link.src)
  );

  // Queue pointer advance with wrap
  function automatic logic [QW-1:0] next_ptr(input logic [QW-1:0] p);
    next_ptr = (p == QW'(RXQ_DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  // Control and status state
  logic serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r;
  logic serial_port_enable_nxt, rx9_nxt, single_receive_enable_nxt, continuous_receive_enable_nxt, address_detect_enable_nxt;
  logic clock_master_select_r, tx9_r, transmit_enable_r, sync_r, baud_high_speed_select_r, transmit_ninth_bit_r;
  logic clock_master_select_nxt, tx9_nxt, transmit_enable_nxt, sync_nxt, baud_high_speed_select_nxt, transmit_ninth_bit_nxt;
  logic receive_interrupt_enable_r, transmit_interrupt_enable_r, peripheral_interrupt_enable_r, gie_r;
  logic receive_interrupt_enable_nxt, transmit_interrupt_enable_nxt, peripheral_interrupt_enable_nxt, gie_nxt;
  logic overrun_error_flag_r, overrun_error_flag_nxt;
  // Receiver state
  logic [8:0]    rsr_r, rsr_nxt;
  logic [3:0]    rcnt_r, rcnt_nxt;
  logic [8:0]    q_r [RXQ_DEPTH];
  logic [8:0]    q_nxt [RXQ_DEPTH];
  logic [QW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [QW:0]   qcnt_r, qcnt_nxt;
  // Transmitter state
  logic [7:0]    txbuf_r, txbuf_nxt;
  logic          txfull_r, txfull_nxt;
  logic [8:0]    tsr_r, tsr_nxt;
  logic [3:0]    tcnt_r, tcnt_nxt, tlen_r, tlen_nxt;
  ssp_tx_state_t tstate_r, tstate_nxt;
  // Bus and output registers
  logic [31:0]   prdata_r, prdata_nxt;
  logic          pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic          dout_r, dout_nxt, doe_n_r, doe_n_nxt;
  logic          irq_r, irq_nxt, wake_r, wake_nxt, resume_r, resume_nxt;
  logic [11:0]   vec_r, vec_nxt;

  // Decoded conditions
  logic       slave_mode, rx_dir, rx_on, tx_on, acc, done, wr, rd, rd_pop;
  logic       push, push_ok, q_full, receive_complete_flag, transmit_buffer_empty_flag, pending;
  logic [3:0] rlen;
  logic [8:0] rx_word, head;
  logic [7:0] rs_val, ts_val, ic_val;
  logic       mapped;

  always_comb begin
    slave_mode = sync_r & serial_port_enable_r & ~clock_master_select_r;
    rx_dir     = continuous_receive_enable_r | single_receive_enable_r;
    // Single-receive bit plays no part in the receiver enable
    rx_on      = slave_mode & continuous_receive_enable_r;
    // Transmit only when both receive bits are clear
    tx_on      = slave_mode & ~rx_dir & transmit_enable_r;
    acc        = psel & penable & ~pready_r;
    done       = psel & penable & pready_r;
    wr         = done & pwrite;
    rd         = done & ~pwrite;
    q_full     = (qcnt_r == QFULL);
    receive_complete_flag       = (qcnt_r != '0);
    transmit_buffer_empty_flag       = ~txfull_r;
    head       = receive_complete_flag ? q_r[rp_r] : 9'h000;
    rd_pop     = rd & (paddr == OFF_RX_DATA) & receive_complete_flag;
    rlen       = rx9_r ? CHAR_LEN_9 : CHAR_LEN_8;
    // New bit lands at its own position, LSB first, ninth bit last
    rx_word         = rsr_r;
    rx_word[rcnt_r] = link.data;
    if (!rx9_r) begin
      rx_word[8] = 1'b0;
    end
    push    = rx_on & link.rise & (rcnt_r == rlen - 4'h1);
    push_ok = push & ~q_full & ~overrun_error_flag_r;
    pending = (receive_complete_flag & receive_interrupt_enable_r) | (transmit_buffer_empty_flag & transmit_interrupt_enable_r);
    rs_val  = {serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r, 1'b0, overrun_error_flag_r, head[8]};
    ts_val  = {clock_master_select_r, tx9_r, transmit_enable_r, sync_r, 1'b0, baud_high_speed_select_r,
               (tstate_r == TXS_IDLE), transmit_ninth_bit_r};
    ic_val  = {gie_r, peripheral_interrupt_enable_r, transmit_interrupt_enable_r, receive_interrupt_enable_r, 2'b00, transmit_buffer_empty_flag, receive_complete_flag};
    mapped  = (paddr == OFF_RCV_STAT) | (paddr == OFF_TX_STAT) | (paddr == OFF_RX_DATA) |
              (paddr == OFF_TX_DATA) | (paddr == OFF_INT_CTRL);
  end

  // APB slave: one wait state, registered answer
  always_comb begin
    pready_nxt  = acc;
    pslverr_nxt = acc & ~mapped;
    prdata_nxt  = 32'h0000_0000;
    if (acc && !pwrite) begin
      unique case (paddr)
        OFF_RCV_STAT: prdata_nxt = {24'h00_0000, rs_val};
        OFF_TX_STAT:  prdata_nxt = {24'h00_0000, ts_val};
        OFF_RX_DATA:  prdata_nxt = {24'h00_0000, head[7:0]};
        OFF_INT_CTRL: prdata_nxt = {24'h00_0000, ic_val};
        default:      prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // Control register writes
  always_comb begin
    {serial_port_enable_nxt, rx9_nxt, single_receive_enable_nxt, continuous_receive_enable_nxt, address_detect_enable_nxt} = {serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r};
    {clock_master_select_nxt, tx9_nxt, transmit_enable_nxt, sync_nxt, baud_high_speed_select_nxt, transmit_ninth_bit_nxt} =
      {clock_master_select_r, tx9_r, transmit_enable_r, sync_r, baud_high_speed_select_r, transmit_ninth_bit_r};
    {gie_nxt, peripheral_interrupt_enable_nxt, transmit_interrupt_enable_nxt, receive_interrupt_enable_nxt} = {gie_r, peripheral_interrupt_enable_r, transmit_interrupt_enable_r, receive_interrupt_enable_r};
    if (wr && paddr == OFF_RCV_STAT) begin
      serial_port_enable_nxt  = pwdata[RS_SERIAL_PORT_ENABLE];
      rx9_nxt   = pwdata[RS_RX9];
      single_receive_enable_nxt  = pwdata[RS_SINGLE_RECEIVE_ENABLE];
      continuous_receive_enable_nxt  = pwdata[RS_CONTINUOUS_RECEIVE_ENABLE];
      // Stored only; no address matching, every character is queued unless the queue is full or overrun is set
      address_detect_enable_nxt = pwdata[RS_ADDRESS_DETECT_ENABLE];
    end
    if (wr && paddr == OFF_TX_STAT) begin
      clock_master_select_nxt = pwdata[TS_CLOCK_MASTER_SELECT];
      tx9_nxt  = pwdata[TS_TX9];
      transmit_enable_nxt = pwdata[TS_TRANSMIT_ENABLE];
      sync_nxt = pwdata[TS_SYNC];
      baud_high_speed_select_nxt = pwdata[TS_BAUD_HIGH_SPEED_SELECT];
      transmit_ninth_bit_nxt = pwdata[TS_TRANSMIT_NINTH_BIT];
    end
    if (wr && paddr == OFF_INT_CTRL) begin
      gie_nxt  = pwdata[IC_GIE];
      peripheral_interrupt_enable_nxt = pwdata[IC_PERIPHERAL_INTERRUPT_ENABLE];
      transmit_interrupt_enable_nxt = pwdata[IC_TRANSMIT_INTERRUPT_ENABLE];
      receive_interrupt_enable_nxt = pwdata[IC_RECEIVE_INTERRUPT_ENABLE];
    end
  end

  // Receiver and receive queue; sleep does not stop slave shifting
  always_comb begin
    rsr_nxt  = rsr_r;
    rcnt_nxt = rcnt_r;
    q_nxt    = q_r;
    wp_nxt   = wp_r;
    rp_nxt   = rp_r;
    qcnt_nxt = qcnt_r;
    // Overrun is sticky while receiving, gone once receive is off
    overrun_error_flag_nxt = rx_on & (overrun_error_flag_r | (push & q_full));
    if (!rx_on) begin
      rcnt_nxt = 4'h0;
    end else if (link.rise) begin
      rsr_nxt  = rx_word;
      rcnt_nxt = push ? 4'h0 : rcnt_r + 4'h1;
    end
    if (push_ok) begin
      q_nxt[wp_r] = rx_word;
      wp_nxt      = next_ptr(wp_r);
    end
    if (rd_pop) begin
      rp_nxt = next_ptr(rp_r);
    end
    if (push_ok && !rd_pop) begin
      qcnt_nxt = qcnt_r + 1'b1;
    end else if (rd_pop && !push_ok) begin
      qcnt_nxt = qcnt_r - 1'b1;
    end
    // Port disable flushes the queue
    if (!serial_port_enable_r) begin
      wp_nxt   = '0;
      rp_nxt   = '0;
      qcnt_nxt = '0;
    end
  end

  // Transmit buffer and shifter
  always_comb begin
    txbuf_nxt  = txbuf_r;
    txfull_nxt = txfull_r;
    tsr_nxt    = tsr_r;
    tcnt_nxt   = tcnt_r;
    tlen_nxt   = tlen_r;
    tstate_nxt = tstate_r;
    unique case (tstate_r)
      TXS_IDLE: begin
        if (tx_on && txfull_r) begin
          // Buffered byte moves into the shifter, buffer reads empty
          tsr_nxt    = {transmit_ninth_bit_r & tx9_r, txbuf_r};
          tlen_nxt   = tx9_r ? CHAR_LEN_9 : CHAR_LEN_8;
          tcnt_nxt   = 4'h0;
          txfull_nxt = 1'b0;
          tstate_nxt = TXS_SHIFT;
        end
      end
      TXS_SHIFT: begin
        if (!tx_on) begin
          tstate_nxt = TXS_IDLE;
        end else if (link.rise) begin
          if (tcnt_r == tlen_r - 4'h1) begin
            tstate_nxt = TXS_IDLE;
          end else begin
            tcnt_nxt = tcnt_r + 4'h1;
          end
        end
      end
    endcase
    // A write always refills the buffer and clears the empty flag
    if (wr && paddr == OFF_TX_DATA) begin
      txbuf_nxt  = pwdata[7:0];
      txfull_nxt = 1'b1;
    end
  end

  // Pin drive and processor requests
  always_comb begin
    doe_n_nxt  = ~tx_on;
    dout_nxt   = (tstate_r == TXS_SHIFT) ? tsr_r[tcnt_r] : 1'b1;
    irq_nxt    = pending & peripheral_interrupt_enable_r & gie_r;
    wake_nxt   = cpu_sleep & pending & peripheral_interrupt_enable_r;
    resume_nxt = wake_nxt & ~gie_r;
    vec_nxt    = irq_nxt ? VECTOR_ADDR : 12'h000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r} <= RCV_STAT_RST[7:3];
      {clock_master_select_r, tx9_r, transmit_enable_r, sync_r} <= TX_STAT_RST[7:4];
      baud_high_speed_select_r   <= TX_STAT_RST[TS_BAUD_HIGH_SPEED_SELECT];
      transmit_ninth_bit_r   <= TX_STAT_RST[TS_TRANSMIT_NINTH_BIT];
      {gie_r, peripheral_interrupt_enable_r, transmit_interrupt_enable_r, receive_interrupt_enable_r} <= INT_CTRL_RST[7:4];
      overrun_error_flag_r   <= 1'b0;
      rsr_r    <= 9'h000;
      rcnt_r   <= 4'h0;
      for (int i = 0; i < RXQ_DEPTH; i++) begin
        q_r[i] <= {1'b0, RX_DATA_RST};
      end
      wp_r     <= '0;
      rp_r     <= '0;
      qcnt_r   <= '0;
      txbuf_r  <= 8'h00;
      txfull_r <= 1'b0;
      tsr_r    <= 9'h000;
      tcnt_r   <= 4'h0;
      tlen_r   <= CHAR_LEN_8;
      tstate_r <= TXS_IDLE;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      dout_r   <= 1'b1;
      doe_n_r  <= 1'b1;
      irq_r    <= 1'b0;
      wake_r   <= 1'b0;
      resume_r <= 1'b0;
      vec_r    <= 12'h000;
    end else begin
      {serial_port_enable_r, rx9_r, single_receive_enable_r, continuous_receive_enable_r, address_detect_enable_r} <= {serial_port_enable_nxt, rx9_nxt, single_receive_enable_nxt, continuous_receive_enable_nxt, address_detect_enable_nxt};
      {clock_master_select_r, tx9_r, transmit_enable_r, sync_r} <= {clock_master_select_nxt, tx9_nxt, transmit_enable_nxt, sync_nxt};
      baud_high_speed_select_r   <= baud_high_speed_select_nxt;
      transmit_ninth_bit_r   <= transmit_ninth_bit_nxt;
      {gie_r, peripheral_interrupt_enable_r, transmit_interrupt_enable_r, receive_interrupt_enable_r} <= {gie_nxt, peripheral_interrupt_enable_nxt, transmit_interrupt_enable_nxt, receive_interrupt_enable_nxt};
      overrun_error_flag_r   <= overrun_error_flag_nxt;
      rsr_r    <= rsr_nxt;
      rcnt_r   <= rcnt_nxt;
      q_r      <= q_nxt;
      wp_r     <= wp_nxt;
      rp_r     <= rp_nxt;
      qcnt_r   <= qcnt_nxt;
      txbuf_r  <= txbuf_nxt;
      txfull_r <= txfull_nxt;
      tsr_r    <= tsr_nxt;
      tcnt_r   <= tcnt_nxt;
      tlen_r   <= tlen_nxt;
      tstate_r <= tstate_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      dout_r   <= dout_nxt;
      doe_n_r  <= doe_n_nxt;
      irq_r    <= irq_nxt;
      wake_r   <= wake_nxt;
      resume_r <= resume_nxt;
      vec_r    <= vec_nxt;
    end
  end

  // Outputs straight from flops
  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign serial_data_pin_out  = dout_r;
  assign serial_data_pin_oe_n = doe_n_r;
  assign irq_o                = irq_r;
  assign wake_o               = wake_r;
  assign resume_next_o        = resume_r;
  assign vector_addr_o        = vec_r;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pin_release: assert property (!tx_on |=> serial_data_pin_oe_n)
    else $error("data pin driven outside slave transmit");
  a_slave_only: assert property (!slave_mode |=> rcnt_r == 4'h0 && serial_data_pin_oe_n)
    else $error("shifting outside slave mode");
  a_ninth_last: assert property (push_ok && rx9_r |-> rx_word[8] == link.data)
    else $error("ninth bit not taken from last clock");
  a_flag_sets: assert property (push_ok |=> receive_complete_flag ##1 (receive_complete_flag || $past(rd_pop)))
    else $error("receive flag not set after character");
  a_overrun_error_flag_clear: assert property (!continuous_receive_enable_r |=> !overrun_error_flag_r)
    else $error("overrun survived receive disable");
  a_pop_empty: assert property (rd_pop && qcnt_r == 1 && !push_ok && serial_port_enable_r |=> !receive_complete_flag)
    else $error("receive flag stayed after queue emptied");
  a_tx_write: assert property (wr && paddr == OFF_TX_DATA |=> txfull_r && !transmit_buffer_empty_flag)
    else $error("transmit flag not cleared by write");
  a_tx_reload: assert property (tstate_r == TXS_SHIFT && tx_on && link.rise &&
      tcnt_r == tlen_r - 4'h1 && txfull_r |=> tstate_r == TXS_IDLE ##1
      (tstate_r == TXS_SHIFT || !tx_on))
    else $error("pending byte not moved to shifter");
  a_irq_vector: assert property (irq_o |-> vector_addr_o == VECTOR_ADDR && $past(gie_r))
    else $error("vector without global enable");
  a_wake_sleep: assert property (wake_o |-> $past(cpu_sleep) && $past(peripheral_interrupt_enable_r))
    else $error("wake without sleep or enable");

  c_rx_char:  cover property (push_ok ##[1:1000] rd_pop);
  c_overrun:  cover property (push && q_full);
  c_tx_back:  cover property (tstate_r == TXS_SHIFT && txfull_r ##[1:400] tstate_r == TXS_IDLE);
  c_wake:     cover property (wake_o && !irq_o);
endmodule
`default_nettype wire

// ==== dv/ssp_master_model.sv ====
/*
  External synchronous master: drives the serial clock and shifts
  characters into or out of the port, least significant bit first.
  Assumes the bench resolves the data wire from both drivers.
*/
`timescale 1ns/1ps
`default_nettype none
module ssp_master_model (
  input  wire logic data_wire,  // Resolved data pin level
  output logic      clk_o,      // Serial clock, low between frames
  output logic      data_o      // Data level when device is not driving
);
  initial begin
    clk_o  = 1'b0;
    data_o = 1'b1;
  end

  // One bit per clock, exactly len clocks, LSB first
  task automatic send(input logic [8:0] ch, input int len);
    for (int i = 0; i < len; i++) begin
      data_o = ch[i];
      #100 clk_o = 1'b1;
      #100 clk_o = 1'b0;
    end
    data_o = ~data_o;  // Released line shows inverse of last bit
  endtask

  // Sample each bit before its rising edge, LSB first
  task automatic recv(input int len, output logic [8:0] ch);
    ch = '0;
    for (int i = 0; i < len; i++) begin
      #100 ch[i] = data_wire;
      clk_o = 1'b1;
      #100 clk_o = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/testbench.sv ====
/*
  Self-checking bench for the slave serial port: APB register tasks,
  receive, nine-bit, overrun, sleep wake and transmit sequences.
  Assumes the master model answers with a 200 ns serial clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import ssp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        cpu_sleep, sck, m_data, d_out, d_oe_n, d_wire, irq, wake, resume;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] vec;
  logic [8:0]  ch;
  logic        err;
  int          num_errors = 0;
  int          total_checks = 0;

  // Wire level: device drives when its enable is low
  assign d_wire = d_oe_n ? m_data : d_out;

  ssp_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_clock_pin(sck), .serial_data_pin_in(d_wire),
    .serial_data_pin_out(d_out), .serial_data_pin_oe_n(d_oe_n), .cpu_sleep(cpu_sleep),
    .irq_o(irq), .wake_o(wake), .resume_next_o(resume), .vector_addr_o(vec));
  ssp_master_model master (.data_wire(d_wire), .clk_o(sck), .data_o(m_data));

  // 40 MHz processor clock
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Totals: %0d checks, %0d mismatches", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      num_errors++;
      conclude();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(rd, exp, what);
  endtask

  // Poll the flag register until bit b is set, bounded
  task automatic wait_bit(input int b);
    int n;
    n = 0;
    do begin
      apb(1'b0, OFF_INT_CTRL, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 100);
    if (rd[b] !== 1'b1) begin
      num_errors++;
      conclude();
    end
  endtask

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cpu_sleep = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rdc(OFF_RCV_STAT, {24'h0, RCV_STAT_RST}, "rcv stat reset");
    rdc(OFF_TX_STAT, {24'h0, TX_STAT_RST}, "tx stat reset");
    rdc(OFF_RX_DATA, {24'h0, RX_DATA_RST}, "rx data reset");
    rdc(OFF_INT_CTRL, 32'h02, "int ctrl reset");
    apb(1'b0, 8'h14, 32'h0);
    check({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset done");
    // Clock master selected: no slave shifting
    apb(1'b1, OFF_TX_STAT, 32'h90);
    apb(1'b1, OFF_RCV_STAT, 32'h90);
    master.send(9'h011, 8);
    rdc(OFF_INT_CTRL, 32'h02, "no rx as master");
    // Slave receive with single-receive set too
    apb(1'b1, OFF_TX_STAT, 32'h10);
    apb(1'b1, OFF_INT_CTRL, 32'hd0);
    apb(1'b1, OFF_RCV_STAT, 32'hb0);
    master.send(9'h0a5, 8);
    wait_bit(IC_RECEIVE_COMPLETE_FLAG);
    check(rd, 32'hd3, "rx flags");
    check({31'h0, irq}, 32'h1, "irq raised");
    check({20'h0, vec}, {20'h0, VECTOR_ADDR}, "vector");
    rdc(OFF_RX_DATA, 32'ha5, "rx byte");
    rdc(OFF_INT_CTRL, 32'hd2, "rx flag clear");
    $display("test receive done");
    // Nine-bit receive
    apb(1'b1, OFF_RCV_STAT, 32'hd0);
    master.send(9'h13c, 9);
    wait_bit(IC_RECEIVE_COMPLETE_FLAG);
    rdc(OFF_RCV_STAT, 32'hd1, "ninth bit");
    rdc(OFF_RX_DATA, 32'h3c, "low byte");
    $display("test nine bit done");
    // Overrun: three characters into a two-deep queue
    apb(1'b1, OFF_RCV_STAT, 32'h90);
    for (int i = 1; i <= 3; i++) master.send(9'(i), 8);
    rdc(OFF_RCV_STAT, 32'h92, "overrun set");
    apb(1'b1, OFF_RCV_STAT, 32'h80);
    rdc(OFF_RCV_STAT, 32'h80, "overrun cleared");
    rdc(OFF_RX_DATA, 32'h01, "first queued");
    rdc(OFF_INT_CTRL, 32'hd3, "flag while queued");
    rdc(OFF_RX_DATA, 32'h02, "second queued");
    rdc(OFF_INT_CTRL, 32'hd2, "flag after drain");
    $display("test overrun done");
    // Receive while asleep, global enable off
    apb(1'b1, OFF_INT_CTRL, 32'h50);
    apb(1'b1, OFF_RCV_STAT, 32'h90);
    @(posedge pclk);
    cpu_sleep <= 1'b1;
    master.send(9'h077, 8);
    wait_bit(IC_RECEIVE_COMPLETE_FLAG);
    check({29'h0, wake, resume, irq}, 32'h6, "sleep wake");
    rdc(OFF_RX_DATA, 32'h77, "sleep byte");
    $display("test sleep receive done");
    // Transmit while asleep, two characters queued
    @(posedge pclk);
    cpu_sleep <= 1'b0;
    apb(1'b1, OFF_RCV_STAT, 32'h80);
    apb(1'b1, OFF_TX_STAT, 32'h30);
    apb(1'b1, OFF_INT_CTRL, 32'h60);
    apb(1'b1, OFF_TX_DATA, 32'h5a);
    apb(1'b1, OFF_TX_DATA, 32'hc3);
    rdc(OFF_INT_CTRL, 32'h60, "tx buffer full");
    check({31'h0, d_oe_n}, 32'h0, "tx drives pin");
    @(posedge pclk);
    cpu_sleep <= 1'b1;
    master.recv(8, ch);
    check({23'h0, ch}, 32'h5a, "first tx char");
    wait_bit(IC_TRANSMIT_BUFFER_EMPTY_FLAG);
    check({31'h0, wake}, 32'h1, "tx wake");
    master.recv(8, ch);
    check({23'h0, ch}, 32'hc3, "second tx char");
    $display("test transmit done");
    conclude();
  end
endmodule
`default_nettype wire
